// ---- adcr_top.v ----
/*
 * Converter control: APB register file, reference and channel select
 * with deferred update, conversion sequencer, result coding and the
 * conversion-done interrupt.
 * Assumes an analog front end that holds afe_code stable at the end
 * of a conversion; converter clock is a divided enable of pclk.
 */
`timescale 1ns/1ps
`include "adcr_consts.vh"
module adcr_top
#(
   parameter CLK_DIV = 8
)
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // Interrupt
   output wire irq,
   // Analog front end
   input wire [11:0] afe_code,
   output reg adc_enable,
   output reg sampling,
   output reg [1:0] ref_sel_active,
   output reg [5:0] chan_sel_active,
   output reg gain_20x,
   output reg temp_sensor_en,
   output reg int_ref_en,
   output reg ext_ref_pin_sel
);
   // ==========================================================
   // Register state
   reg [7:0] select_q;
   reg bipolar_q;
   reg enable_q;
   reg free_q;
   reg start_pend_q;
   reg busy_q;
   reg first_q;
   reg [4:0] cnt_q;
   reg [9:0] result_q;
   reg [0:0] status_q;
   reg [0:0] irq_en_q;
   reg [7:0] div_q;
   reg tick;
   wire [11:0] code_s;
   wire [9:0] coded;
   wire wr;
   wire rd;
   wire start_wr;
   wire [2:0] idx;
   wire hit_ctrl_a;
   wire done_ev;
   wire last_cyc;
   wire diff_active;
   reg mapped;

   // ==========================================================
   // APB decode: no wait states
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign idx = paddr[4:2];
   assign hit_ctrl_a = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00)
      && (idx == `ADCR_IDX_CTRL_A);

   always @*
   begin
      mapped = 1'b0;
      prdata = 32'h0000_0000;
      if (paddr[11:5] == 7'h00 && paddr[1:0] == 2'b00)
      begin
         case (idx)
            `ADCR_IDX_CTRL_B:
            begin
               mapped = 1'b1;
               prdata[`ADCR_CB_BIPOLAR] = bipolar_q;
            end
            `ADCR_IDX_RES_LO:
            begin
               mapped = 1'b1;
               prdata[7:0] = result_q[7:0];
            end
            `ADCR_IDX_RES_HI:
            begin
               mapped = 1'b1;
               prdata[1:0] = result_q[9:8];
            end
            `ADCR_IDX_CTRL_A:
            begin
               mapped = 1'b1;
               prdata[`ADCR_CA_ENABLE] = enable_q;
               prdata[`ADCR_CA_START] = busy_q | start_pend_q;
               prdata[`ADCR_CA_FREE] = free_q;
            end
            `ADCR_IDX_SELECT:
            begin
               mapped = 1'b1;
               prdata[7:0] = select_q;
            end
            default:
               mapped = 1'b0;
         endcase
      end
      else if (paddr == `ADCR_ADDR_STATUS)
      begin
         mapped = 1'b1;
         prdata[0] = status_q[`ADCR_EVT_DONE];
      end
      else if (paddr == `ADCR_ADDR_CLEAR)
         mapped = 1'b1;
      else if (paddr == `ADCR_ADDR_IRQ_EN)
      begin
         mapped = 1'b1;
         prdata[0] = irq_en_q[0];
      end
   end

   assign pslverr = psel && penable && !mapped;

   // ==========================================================
   // Software registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         select_q <= `ADCR_SELECT_RST;
         bipolar_q <= 1'b0;
         enable_q <= 1'b0;
         free_q <= 1'b0;
         irq_en_q <= 1'b0;
      end
      else if (wr && mapped && pstrb[0])
      begin
         if (paddr[11:5] == 7'h00 && idx == `ADCR_IDX_SELECT)
            select_q <= pwdata[7:0];
         if (paddr[11:5] == 7'h00 && idx == `ADCR_IDX_CTRL_B)
            bipolar_q <= pwdata[`ADCR_CB_BIPOLAR];
         if (hit_ctrl_a)
         begin
            enable_q <= pwdata[`ADCR_CA_ENABLE];
            free_q <= pwdata[`ADCR_CA_FREE];
         end
         if (paddr == `ADCR_ADDR_IRQ_EN)
            irq_en_q <= pwdata[0:0];
      end
   end

   // ==========================================================
   // Converter clock enable
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_q <= 8'h00;
         tick <= 1'b0;
      end
      else if (div_q == CLK_DIV[7:0] - 8'h01)
      begin
         div_q <= 8'h00;
         tick <= enable_q;
      end
      else
      begin
         div_q <= div_q + 8'h01;
         tick <= 1'b0;
      end
   end

   // ==========================================================
   // Conversion sequencer
   assign last_cyc = busy_q && (cnt_q == 5'd1);
   assign done_ev = tick && last_cyc;
   assign start_wr = wr && pstrb[0] && hit_ctrl_a && pwdata[`ADCR_CA_START];

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_pend_q <= 1'b0;
         busy_q <= 1'b0;
         first_q <= 1'b1;
         cnt_q <= 5'd0;
      end
      else if (!enable_q)
      begin
         // Disabling aborts a conversion; next one reinitialises.
         // A start written together with enable must not be lost.
         start_pend_q <= start_wr && pwdata[`ADCR_CA_ENABLE];
         busy_q <= 1'b0;
         first_q <= 1'b1;
         cnt_q <= 5'd0;
      end
      else
      begin
         if (start_wr)
            start_pend_q <= 1'b1;
         if (tick)
         begin
            if (busy_q && !last_cyc)
               cnt_q <= cnt_q - 5'd1;
            else if (last_cyc && free_q)
               cnt_q <= `ADCR_CONV_CYC;
            else if (last_cyc)
               busy_q <= 1'b0;
            else if (start_pend_q)
            begin
               busy_q <= 1'b1;
               start_pend_q <= 1'b0;
               first_q <= 1'b0;
               cnt_q <= first_q ? `ADCR_FIRST_CYC : `ADCR_CONV_CYC;
            end
         end
      end
   end

   // ==========================================================
   // Selection locked during a conversion
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref_sel_active <= 2'b00;
         chan_sel_active <= 6'h00;
      end
      else if (!busy_q || last_cyc)
      begin
         ref_sel_active <= select_q[`ADCR_SEL_REF_HI:`ADCR_SEL_REF_LO];
         chan_sel_active <= select_q[`ADCR_SEL_CH_HI:0];
      end
   end

   assign diff_active = (chan_sel_active >= `ADCR_CH_DIFF_LO &&
      chan_sel_active <= `ADCR_CH_DIFF_HI) ||
      (chan_sel_active >= `ADCR_CH_CAL_LO &&
      chan_sel_active <= `ADCR_CH_CAL_HI) ||
      (chan_sel_active >= `ADCR_CH_REV_LO);

   // ==========================================================
   // Analog controls
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         adc_enable <= 1'b0;
         sampling <= 1'b0;
         gain_20x <= 1'b0;
         temp_sensor_en <= 1'b0;
         int_ref_en <= 1'b0;
         ext_ref_pin_sel <= 1'b0;
      end
      else
      begin
         adc_enable <= enable_q;
         sampling <= busy_q;
         gain_20x <= diff_active && chan_sel_active[0];
         temp_sensor_en <= (chan_sel_active == `ADCR_CH_SENSOR);
         // Reserved code leaves both references idle
         int_ref_en <= (ref_sel_active == `ADCR_REF_INTERNAL);
         ext_ref_pin_sel <= (ref_sel_active == `ADCR_REF_PIN);
      end
   end

   // ==========================================================
   // Result path
   adcr_sync #(.W(12)) u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .din(afe_code),
      .dout(code_s)
   );

   adcr_coder u_coder
   (
      .differential(diff_active),
      .bipolar(bipolar_q),
      .raw_code(code_s),
      .result(coded)
   );

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         result_q <= `ADCR_RESULT_RST;
      else if (done_ev)
         result_q <= coded;
   end

   // ==========================================================
   // Done flag and interrupt; a set in the clear cycle wins
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_q <= 1'b0;
      else if (done_ev)
         status_q[`ADCR_EVT_DONE] <= 1'b1;
      else if (wr && pstrb[0] && paddr == `ADCR_ADDR_CLEAR &&
         pwdata[`ADCR_EVT_DONE])
         status_q[`ADCR_EVT_DONE] <= 1'b0;
   end

   assign irq = |(status_q & irq_en_q);
endmodule // adcr_top

// ---- adcr_consts.vh ----
/*
 * Constants of the converter control block: register indices, field
 * positions, reset values, coding limits and conversion cycle counts.
 * Assumes a 32-bit APB with each register on one aligned word.
 */
// Contract
// - Result registers loaded when done flag rises
// - Single-ended: unsigned code, 0 to 0x3ff
// - Unipolar differential: unsigned, negative saturates to zero
// - Bipolar differential: two's complement, 512 scale
// - Result bit 9 in high register is sign
// - Reset unipolar; bipolar bit selects bipolar mode
// - Sensor channel code enables temperature sensor
// - Reference change waits for conversion completion
// - Reference field decode: supply, pin, internal, reserved
// - External pin selected turns internal reference off
// - Select register: reference 7:6, channel 5:0
// - Channel change waits for conversion completion
`ifndef ADCR_CONSTS_VH
`define ADCR_CONSTS_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define ADCR_IDX_CTRL_B 3'd3
`define ADCR_IDX_RES_LO 3'd4
`define ADCR_IDX_RES_HI 3'd5
`define ADCR_IDX_CTRL_A 3'd6
`define ADCR_IDX_SELECT 3'd7
`define ADCR_ADDR_STATUS 12'h020
`define ADCR_ADDR_CLEAR 12'h024
`define ADCR_ADDR_IRQ_EN 12'h028

// ==========================================================
// Field positions
`define ADCR_CA_ENABLE 0
`define ADCR_CA_START 1
`define ADCR_CA_FREE 2
`define ADCR_CB_BIPOLAR 0
`define ADCR_SEL_REF_HI 7
`define ADCR_SEL_REF_LO 6
`define ADCR_SEL_CH_HI 5
`define ADCR_EVT_DONE 0

// ==========================================================
// Reset values
`define ADCR_SELECT_RST 8'h00
`define ADCR_RESULT_RST 10'h000

// ==========================================================
// Reference codes and channel codes
`define ADCR_REF_SUPPLY 2'b00
`define ADCR_REF_PIN 2'b01
`define ADCR_REF_INTERNAL 2'b10
`define ADCR_CH_SENSOR 6'h22
`define ADCR_CH_DIFF_LO 6'h08
`define ADCR_CH_DIFF_HI 6'h1f
`define ADCR_CH_CAL_LO 6'h23
`define ADCR_CH_CAL_HI 6'h27
`define ADCR_CH_REV_LO 6'h28

// ==========================================================
// Result coding limits
`define ADCR_UNI_MAX 12'sh3ff
`define ADCR_BIP_MAX 12'sh1ff
`define ADCR_BIP_MIN -12'sh200

// ==========================================================
// Conversion lengths in converter clock cycles
`define ADCR_CONV_CYC 5'd13
`define ADCR_FIRST_CYC 5'd25

`endif

// ---- adcr_sync.v ----
/*
 * Two-stage synchroniser for a bus that is held stable while it is read.
 * Assumes the source holds its value for the whole conversion.
 */
`timescale 1ns/1ps
module adcr_sync
#(
   parameter W = 12
)
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Data
   input wire [W-1:0] din,
   output reg [W-1:0] dout
);
   reg [W-1:0] meta_q;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= {W{1'b0}};
         dout <= {W{1'b0}};
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule // adcr_sync

// ---- adcr_coder.v ----
/*
 * Result coder: turns the front end's signed difference code into the
 * 10-bit result for single-ended, unipolar and bipolar conversions.
 * Assumes raw_code is (Vpos - Vneg) * 1024 / Vref * gain, in LSBs.
 */
`timescale 1ns/1ps
`include "adcr_consts.vh"
module adcr_coder
(
   // Conversion kind
   input wire differential,
   input wire bipolar,
   // Codes
   input wire signed [11:0] raw_code,
   output reg [9:0] result
);
   reg signed [11:0] half;

   always @*
   begin
      half = raw_code >>> 1;
      result = 10'h000;
      if (differential && bipolar)
      begin
         if (half > `ADCR_BIP_MAX)
            result = 10'h1ff;
         else if (half < `ADCR_BIP_MIN)
            result = 10'h200;
         else
            result = half[9:0];
      end
      else if (raw_code < 12'sh000)
         result = 10'h000;
      else if (raw_code > `ADCR_UNI_MAX)
         result = 10'h3ff;
      else
         result = raw_code[9:0];
   end
endmodule // adcr_coder

// ---- adcr_monitor.sv ----
/* Checker of the converter control ports: selection decode, lock of
   the selection during a conversion and the APB answers.
   Assumes it is bound into adcr_top and sees only its ports. */
`timescale 1ns/1ps
`include "adcr_consts.vh"
module adcr_monitor
(
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // APB
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic pready,
   input logic pslverr,
   input logic [31:0] prdata,
   // Front end
   input logic sampling,
   input logic [1:0] ref_sel_active,
   input logic [5:0] chan_sel_active,
   input logic gain_20x,
   input logic temp_sensor_en,
   input logic int_ref_en,
   input logic ext_ref_pin_sel
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   function automatic logic dif(logic [5:0] c);
      return (c >= `ADCR_CH_DIFF_LO && c <= `ADCR_CH_DIFF_HI) ||
         c >= `ADCR_CH_CAL_LO;
   endfunction

   // ==========================================================
   // Assertions
   a_ref_internal: assert property (
      ##1 int_ref_en == ($past(ref_sel_active) == `ADCR_REF_INTERNAL))
      else $error("internal reference enable wrong");
   a_ref_pin: assert property (
      ##1 ext_ref_pin_sel == ($past(ref_sel_active) == `ADCR_REF_PIN))
      else $error("reference pin select wrong");
   a_ref_excl: assert property (
      ext_ref_pin_sel |-> !int_ref_en)
      else $error("internal reference on with pin reference");
   a_sensor_en: assert property (
      ##1 temp_sensor_en == ($past(chan_sel_active) == `ADCR_CH_SENSOR))
      else $error("sensor enable wrong");
   a_gain_sel: assert property (
      ##1 gain_20x == (dif($past(chan_sel_active)) &&
      $past(chan_sel_active[0]))) else $error("gain select wrong");
   // Last converter cycle is far beyond 8 clocks even at CLK_DIV 2
   a_sel_locked: assert property (
      $rose(sampling) |=> ($stable(ref_sel_active) &&
      $stable(chan_sel_active))[*8]) else $error("selection moved");
   a_apb_ready: assert property (
      psel && penable |-> pready) else $error("no ready in access");
   a_err_rdata: assert property (
      pslverr && !pwrite |-> prdata == 32'h0) else $error("error read data");

   // ==========================================================
   // Coverage
   c_conv_end: cover property ($fell(sampling));
   c_sensor: cover property (temp_sensor_en && int_ref_en);
   c_err: cover property (pslverr);
endmodule // adcr_monitor

// ---- adc_result_and_reference_select_bench.sv ----
/* Self-checking bench of the converter control block: APB tasks, an
   integer result model, register, interrupt and selection scenarios.
   Assumes adcr_top with CLK_DIV 2 and an ideal front-end code. */
`timescale 1ns/1ps
module adc_result_and_reference_select_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic adc_enable, sampling, gain_20x, temp_sensor_en, int_ref_en;
   logic ext_ref_pin_sel, err, bip, dif;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [11:0] afe_code;
   logic signed [11:0] a;
   logic [1:0] ref_sel_active;
   logic [5:0] chan_sel_active, ch;
   logic [7:0] sv;
   logic [9:0] r10;
   int errors, n_compared, seed, i, n, e;
   logic [5:0] chans [4] = '{6'h00, 6'h08, 6'h22, 6'h09};
   logic [11:0] fixed [8] = '{12'h3ff, 12'h400, 12'hfff, 12'h3fe,
      12'h3ff, 12'h400, 12'h800, 12'hfff};

   adcr_top #(.CLK_DIV(2)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .irq(irq), .afe_code(afe_code),
      .adc_enable(adc_enable), .sampling(sampling),
      .ref_sel_active(ref_sel_active), .chan_sel_active(chan_sel_active),
      .gain_20x(gain_20x), .temp_sensor_en(temp_sensor_en),
      .int_ref_en(int_ref_en), .ext_ref_pin_sel(ext_ref_pin_sel));

   // ==========================================================
   // Tasks and model
   task stop_test;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask

   // One idle cycle after each transfer keeps psel single-driven
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   function int model(input int v, input logic df, input logic bp);
      int lo, hi;
      if (df && bp)
         v = v >>> 1;
      lo = (df && bp) ? -512 : 0;
      hi = (df && bp) ? 511 : 1023;
      v = v < lo ? lo : (v > hi ? hi : v);
      return v & 32'h3ff;
   endfunction

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   initial
   begin
      repeat (30000) @(posedge pclk);
      errors++;
      stop_test;
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, afe_code} = '0;
      pstrb = 4'hf;
      presetn = 1'b0;
      seed = 32'hfc6e;
      errors = 0;
      n_compared = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h01c, 32'h0);
      chk("select_rst", rd, 0);
      apb(1'b0, 12'h014, 32'h0);
      chk("res_hi_rst", rd, 0);
      apb(1'b0, 12'h100, 32'h0);
      chk("unmapped_err", err, 1);
      chk("unmapped_rd", rd, 0);
      sv = $random(seed);
      sv[7] = 1'b0;
      apb(1'b1, 12'h01c, {24'h0, sv});
      apb(1'b0, 12'h01c, 32'h0);
      chk("select_rw", rd, sv);
      apb(1'b1, 12'h028, 32'h1);
      for (i = 0; i < 16; i++)
      begin
         bip = i[2];
         ch = chans[i % 4];
         dif = ch[3]; // Only 08 and 09 of the table are differential
         a = i < 8 ? fixed[i] : 12'($random(seed));
         if (i >= 4)
            apb(1'b1, 12'h00c, {31'h0, bip});
         apb(1'b1, 12'h01c, {26'h0, ch});
         afe_code <= a;
         repeat (30) @(posedge pclk);
         apb(1'b1, 12'h018, 32'h3);
         for (n = 0; n < 300 && irq !== 1'b1; n++) @(posedge pclk);
         chk("done_irq", irq, 1);
         apb(1'b0, 12'h010, 32'h0);
         r10[7:0] = rd[7:0];
         apb(1'b0, 12'h014, 32'h0);
         r10[9:8] = rd[1:0];
         e = model(a, dif, bip);
         chk("result", r10, e);
         chk("sign", r10[9], e[9]);
         apb(1'b1, 12'h024, 32'h1);
         chk("irq_clr", irq, 0);
      end
      apb(1'b1, 12'h028, 32'h0);
      apb(1'b1, 12'h01c, 32'h08);
      apb(1'b1, 12'h018, 32'h3);
      for (n = 0; n < 20 && sampling !== 1'b1; n++) @(posedge pclk);
      apb(1'b1, 12'h01c, 32'ha2);
      repeat (3) @(posedge pclk);
      chk("chan_held", chan_sel_active, 6'h08);
      chk("ref_held", ref_sel_active, 2'b00);
      chk("adc_enable", adc_enable, 1);
      for (n = 0; n < 300 && sampling !== 1'b0; n++) @(posedge pclk);
      repeat (3) @(posedge pclk);
      chk("irq_masked", irq, 0);
      chk("chan_new", chan_sel_active, 6'h22);
      chk("ref_new", ref_sel_active, 2'b10);
      chk("sensor_on", temp_sensor_en, 1);
      chk("int_ref_on", int_ref_en, 1);
      apb(1'b1, 12'h028, 32'h1);
      chk("irq_unmask", irq, 1);
      apb(1'b0, 12'h020, 32'h0);
      chk("status", rd, 1);
      apb(1'b1, 12'h024, 32'h1);
      chk("irq_cleared", irq, 0);
      for (n = 0; n < 3; n++)
      begin
         apb(1'b1, 12'h01c, n << 6);
         repeat (3) @(posedge pclk);
         chk("int_ref", int_ref_en, n == 2);
         chk("ext_pin", ext_ref_pin_sel, n == 1);
      end
      // Second reset in mid-run: bipolar bit and selection return to zero
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h00c, 32'h0);
      chk("ctrl_b_rst", rd, 0);
      apb(1'b0, 12'h01c, 32'h0);
      chk("select_rst2", rd, 0);
      chk("adc_enable_rst", adc_enable, 0);
      stop_test;
   end
endmodule // adc_result_and_reference_select_bench

bind adcr_top adcr_monitor u_mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
   .pslverr(pslverr), .prdata(prdata), .sampling(sampling),
   .ref_sel_active(ref_sel_active), .chan_sel_active(chan_sel_active),
   .gain_20x(gain_20x), .temp_sensor_en(temp_sensor_en),
   .int_ref_en(int_ref_en), .ext_ref_pin_sel(ext_ref_pin_sel));
